// ---- efs_cfg.svh ----
// Register map, field layout and timing constants of the enable/fault supervisor
`ifndef EFS_CFG_SVH
`define EFS_CFG_SVH
`define EFS_OFF_CTRL     12'h000
`define EFS_OFF_DELAY    12'h004
`define EFS_OFF_STATUS   12'h008
`define EFS_OFF_INTSTAT  12'h00c
`define EFS_OFF_INTMASK  12'h010
`define EFS_OFF_ERRCODE  12'h014
`define EFS_OFF_LIMITS   12'h018
`define EFS_OFF_THRESH   12'h01c
`define EFS_CTRL_CURIN   0
`define EFS_CTRL_BREAK   1
`define EFS_DELAY_RST    32'h0000_0000
`define EFS_THRESH_RST   16'h0fa0
`define EFS_UNDER_RST    16'h0080
`define EFS_OVER_RST     16'h0640
`define EFS_FB_OVER_RST  16'h0580
`define EFS_FLASH_NS     250000000
`define EFS_CLK_MHZ      250
`define EFS_US_NS        1000
`define EFS_ERR_OPER     5'h01
`define EFS_ERR_FBWIRE   5'h02
`define EFS_ERR_OVERCUR  5'h03
`define EFS_ERR_SETA     5'h05
`define EFS_ERR_SETB     5'h06
`define EFS_ERR_OUTWIRE  5'h08
`define EFS_ERR_FBOVER   5'h0b
`define EFS_ERR_SETAOVR  5'h0f
`define EFS_ERR_SETBOVR  5'h10
`define EFS_NEV          8
`endif

// ---- efs_ctrl_model.sv ----
// External controller model: drives enable, sees fault pin
`timescale 1ns/1ns
module efs_ctrl_model (
  // Clock
  input  wire logic clock,
  // Supervisor pins
  input  wire logic faultOutTerminal,
  output logic      enableTerminal
);
  initial enableTerminal = 1'b0;
  // Level change right after an edge
  task setEn(input logic v);
    @(posedge clock);
    enableTerminal <= v;
  endtask : setEn
  // clear by enable drop, supply kept
  task clearFault;
    setEn(1'b0);
    // Wait for the fault pin to recover, bounded; a hang shows in the bench
    for (int n = 0; n < 8 && faultOutTerminal !== 1'b1; n++) @(posedge clock);
    repeat (2) @(posedge clock);
    setEn(1'b1);
  endtask : clearFault
endmodule : efs_ctrl_model

// ---- efs_pkg.sv ----
// Types of the enable/fault supervisor
package efs_pkg;
  typedef enum logic [3:0] {
    EFS_IDLE  = 4'b0001,
    EFS_DELAY = 4'b0010,
    EFS_RUN   = 4'b0100,
    EFS_FAULT = 4'b1000
  } efs_state_type;
  typedef enum logic [1:0] {
    EFS_LED_OFF = 2'h0, EFS_LED_GREEN = 2'h1, EFS_LED_YELLOW = 2'h2, EFS_LED_RED = 2'h3
  } efs_led_type;
endpackage : efs_pkg

// ---- efs_supervisor.sv ----
// Enable sequencing, fault latch, status light and error reporting with APB registers
//
// Summary of operation
// - Enable going active turns the status light yellow.
// - Nonzero enable delay flashes yellow and keeps output stages off meanwhile.
// - Delay expiry gives steady yellow and releases the output stages.
// - Summed output stage current above threshold switches stages off.
// - Overcurrent drives fault output low and the light red at once.
// - Fault stays latched until enable falls with cause gone; stages return at the next enable on.
// - Current input with break detection errors when current falls below limit.
// - Command input current above overload limit disconnects input and errors.
// - Registers stay writable during a fault; clearing still needs enable toggle.
// - Codes 1,2,3,5,6,8 report operation, wire break and overcurrent errors.
// - Codes 11,15,16 report negative or overload feedback and set-value current.
// - Light is green with supply present and nothing overriding it.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "efs_cfg.svh"
module efs_supervisor
  import efs_pkg::*;
#(
  parameter int CW        = 32,
  parameter int FLASH_NS  = `EFS_FLASH_NS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from outside (asynchronous)
  input  wire logic        enableTerminal,
  // Measurements and fault causes from the analog side
  input  wire logic [15:0] stageCurrentSum,
  input  wire logic [15:0] commandCurrent,
  input  wire logic [15:0] feedbackCurrent,
  input  wire logic        feedbackNegative,
  input  wire logic        commandNegative,
  input  wire logic        setANegOrOver,
  input  wire logic        setAWireBreak,
  input  wire logic        setBWireOrOverV,
  input  wire logic        feedbackWireBreak,
  input  wire logic        outStageWireBreak,
  input  wire logic        operationError,
  // Outputs
  output logic             stagesEnable,
  output logic             faultOutTerminal,
  output logic             commandInputConnect,
  output efs_led_type      statusLed,
  output logic             irq
);

  // Blink half period in clocks; the product is formed in 64 bits because
  // nanoseconds times megahertz overflows 32 bits at the default setting
  localparam longint FLASH_PROD = longint'(FLASH_NS) * longint'(`EFS_CLK_MHZ);
  localparam int     FLASH_RAW  = int'(FLASH_PROD / longint'(`EFS_US_NS));
  // A zero count would stall the timebase; one clock is the shortest half period
  localparam int     FLASH_CYC  = (FLASH_RAW < 1) ? 1 : FLASH_RAW;

  typedef struct packed {
    // Enable pin path
    logic [1:0]          enSync;
    logic                enPrev;
    // Sequencer
    efs_state_type       state;
    logic [CW-1:0]       delayCnt;
    // Flash timebase
    logic [31:0]         flashCnt;
    logic                blink;
    // Software settings, writable in every state
    logic [1:0]          ctrl;
    logic [CW-1:0]       delayParam;
    logic [15:0]         thresh;
    logic [15:0]         underLim;
    logic [15:0]         overLim;
    logic [15:0]         fbOverLim;
    // Event, interrupt and error state
    logic [`EFS_NEV-1:0] intStat;
    logic [`EFS_NEV-1:0] intMask;
    logic [4:0]          errCode;
    logic                cmdOff;
    // Bus answer
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    // Pin and light outputs
    logic                stages;
    logic                faultOut;
    efs_led_type         led;
    logic                irq;
  } efs_regs_type;

  efs_regs_type cur_r;
  efs_regs_type cur_nxt;

  // Lowest active error code wins; only assigned codes can come out.
  // A feedback wire break shares event bit 5 with overload but has its own code.
  function automatic logic [4:0] efs_code(input logic [`EFS_NEV-1:0] ev,
                                          input logic                fbWire);
    logic [4:0] c;
    c = 5'h00;
    if (ev[7]) c = `EFS_ERR_SETBOVR;
    if (ev[6]) c = `EFS_ERR_SETAOVR;
    if (ev[5]) c = `EFS_ERR_FBOVER;
    if (ev[4]) c = `EFS_ERR_OUTWIRE;
    if (ev[3]) c = `EFS_ERR_SETB;
    if (ev[2]) c = `EFS_ERR_SETA;
    if (ev[1]) c = `EFS_ERR_OVERCUR;
    if (fbWire) c = `EFS_ERR_FBWIRE;
    if (ev[0]) c = `EFS_ERR_OPER;
    return c;
  endfunction : efs_code

  // Decoded pin and measurement conditions
  logic                enLvl;
  logic                enRise;
  logic                enFall;
  logic                overCur;
  logic                underCur;
  logic                overLoad;
  logic [`EFS_NEV-1:0] events;
  logic                anyCause;
  // Bus decode
  logic                apbAcc;
  logic                apbWr;
  logic                apbRd;

  // Next-state logic
  always_comb begin
    cur_nxt = cur_r;
    enLvl   = cur_r.enSync[1];
    enRise  = enLvl && !cur_r.enPrev;
    enFall  = !enLvl && cur_r.enPrev;
    overCur = stageCurrentSum > cur_r.thresh;
    // cable break only on current input
    underCur = cur_r.ctrl[`EFS_CTRL_CURIN] && cur_r.ctrl[`EFS_CTRL_BREAK]
               && (commandCurrent < cur_r.underLim);
    overLoad = commandCurrent > cur_r.overLim;
    events[0] = operationError;
    events[1] = overCur;
    events[2] = setAWireBreak;
    events[3] = setBWireOrOverV || underCur;
    events[4] = outStageWireBreak;
    events[5] = feedbackNegative || (feedbackCurrent > cur_r.fbOverLim) || feedbackWireBreak;
    events[6] = setANegOrOver;
    events[7] = commandNegative || overLoad;
    anyCause = |events;

    // Sync chain for the enable pin; only the second stage feeds logic,
    // so a pin edge near the clock cannot split the sequencer's decision
    cur_nxt.enSync = {cur_r.enSync[0], enableTerminal};
    cur_nxt.enPrev = enLvl;
    // Flash timebase
    if (cur_r.flashCnt >= 32'(FLASH_CYC - 1)) begin
      cur_nxt.flashCnt = '0;
      cur_nxt.blink    = !cur_r.blink;
    end else begin
      cur_nxt.flashCnt = cur_r.flashCnt + 32'h0000_0001;
    end

    // code never outside assigned set
    // The code keeps the last cause after it goes, for diagnosis after the fault
    if (anyCause) cur_nxt.errCode = efs_code(events, feedbackWireBreak);
    if (events[7]) cur_nxt.cmdOff = 1'b1;

    unique case (cur_r.state)
      EFS_IDLE: begin
        if (enRise) begin
          cur_nxt.delayCnt = cur_r.delayParam;
          cur_nxt.state    = (cur_r.delayParam != '0) ? EFS_DELAY : EFS_RUN;
        end
      end
      EFS_DELAY: begin
        if (!enLvl) cur_nxt.state = EFS_IDLE;
        else if (cur_r.delayCnt <= CW'(1)) cur_nxt.state = EFS_RUN;
        else cur_nxt.delayCnt = cur_r.delayCnt - CW'(1);
      end
      EFS_RUN: begin
        if (!enLvl) cur_nxt.state = EFS_IDLE;
      end
      EFS_FAULT: begin
        // clear only by enable cycle with cause gone
        // the enable must then rise again before the stages return
        if (enFall && !anyCause) cur_nxt.state = EFS_IDLE;
      end
    endcase
    // any cause latches fault
    // A cause also latches while idle, so enabling into a fault is refused
    if (anyCause) cur_nxt.state = EFS_FAULT;
    if (cur_nxt.state == EFS_IDLE) cur_nxt.cmdOff = 1'b0;

    // Outputs from the next state so they move together
    // stages only in run; fault low with red
    cur_nxt.stages   = (cur_nxt.state == EFS_RUN);
    cur_nxt.faultOut = (cur_nxt.state != EFS_FAULT);
    unique case (cur_nxt.state)
      EFS_IDLE:  cur_nxt.led = EFS_LED_GREEN;
      EFS_DELAY: cur_nxt.led = cur_nxt.blink ? EFS_LED_YELLOW : EFS_LED_OFF;
      EFS_RUN:   cur_nxt.led = EFS_LED_YELLOW;
      EFS_FAULT: cur_nxt.led = EFS_LED_RED;
    endcase

    // APB: one wait-free access phase; writes accepted in any state
    // A write lands only at the edge where pready is seen high
    apbAcc = psel && penable;
    apbWr  = apbAcc && pwrite && cur_r.pready;
    apbRd  = apbAcc && !pwrite;
    // Ready is raised by the setup cycle, so it stands in the first access cycle
    cur_nxt.pready  = psel && !penable;
    cur_nxt.pslverr = 1'b0;
    cur_nxt.prdata  = '0;
    if (apbWr) begin
      unique case (paddr)
        `EFS_OFF_CTRL:    cur_nxt.ctrl = pwdata[1:0];
        `EFS_OFF_DELAY:   cur_nxt.delayParam = pwdata[CW-1:0];
        `EFS_OFF_INTMASK: cur_nxt.intMask = pwdata[`EFS_NEV-1:0];
        `EFS_OFF_LIMITS:  {cur_nxt.overLim, cur_nxt.underLim} = pwdata;
        `EFS_OFF_THRESH:  {cur_nxt.fbOverLim, cur_nxt.thresh} = pwdata;
        `EFS_OFF_STATUS, `EFS_OFF_INTSTAT, `EFS_OFF_ERRCODE: ;
        // Unmapped writes are dropped without an error response
        default:          cur_nxt.pslverr = 1'b0;
      endcase
    end

    // Read data prepared in the setup cycle, valid with pready
    // Status and interrupt words are a cycle old when they reach the bus
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `EFS_OFF_CTRL:    cur_nxt.prdata = {30'h0, cur_r.ctrl};
        `EFS_OFF_DELAY:   cur_nxt.prdata = 32'(cur_r.delayParam);
        `EFS_OFF_STATUS:  cur_nxt.prdata = {24'h0, cur_r.cmdOff, cur_r.faultOut,
                                            cur_r.stages, 1'b0, cur_r.state};
        `EFS_OFF_INTSTAT: cur_nxt.prdata = {24'h0, cur_r.intStat};
        `EFS_OFF_INTMASK: cur_nxt.prdata = {24'h0, cur_r.intMask};
        `EFS_OFF_ERRCODE: cur_nxt.prdata = {27'h0, cur_r.errCode};
        `EFS_OFF_LIMITS:  cur_nxt.prdata = {cur_r.overLim, cur_r.underLim};
        `EFS_OFF_THRESH:  cur_nxt.prdata = {cur_r.fbOverLim, cur_r.thresh};
        default:          cur_nxt.prdata = '0;
      endcase
    end

    // Ready is a one-cycle pulse; it never stretches into a second access cycle
    if (apbAcc && !cur_r.pready) begin
      cur_nxt.pready = 1'b0;
    end else if (apbAcc) begin
      cur_nxt.pready = 1'b0;
      if (!pwrite && !(paddr inside {`EFS_OFF_CTRL, `EFS_OFF_DELAY, `EFS_OFF_STATUS,
          `EFS_OFF_INTSTAT, `EFS_OFF_INTMASK, `EFS_OFF_ERRCODE, `EFS_OFF_LIMITS,
          `EFS_OFF_THRESH}))
        cur_nxt.pslverr = 1'b0;
    end

    // Sticky events, read clears, a new event wins over the clear
    if (apbRd && cur_r.pready && paddr == `EFS_OFF_INTSTAT) cur_nxt.intStat = events;
    else cur_nxt.intStat = cur_r.intStat | events;
    // Level interrupt; the new mask acts at the same edge as its write
    cur_nxt.irq = |(cur_nxt.intStat & cur_nxt.intMask);
  end

  // All state in one register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur_r            <= '0;
      cur_r.state      <= EFS_IDLE;
      cur_r.delayParam <= CW'(`EFS_DELAY_RST);
      // Limits start at their defaults so a fresh part is already protected
      cur_r.thresh     <= `EFS_THRESH_RST;
      cur_r.underLim   <= `EFS_UNDER_RST;
      cur_r.overLim    <= `EFS_OVER_RST;
      cur_r.fbOverLim  <= `EFS_FB_OVER_RST;
      // Fault pin idles high: no fault
      cur_r.faultOut   <= 1'b1;
      cur_r.led        <= EFS_LED_GREEN;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata              = cur_r.prdata;
  assign pready              = cur_r.pready;
  assign pslverr             = cur_r.pslverr;
  assign stagesEnable        = cur_r.stages;
  assign faultOutTerminal    = cur_r.faultOut;
  assign commandInputConnect = !cur_r.cmdOff;
  assign statusLed           = cur_r.led;
  assign irq                 = cur_r.irq;

endmodule : efs_supervisor

// ---- efs_supervisor_sva.sv ----
// Port checker for the enable/fault supervisor
`timescale 1ns/1ns
`include "efs_cfg.svh"
module efs_supervisor_sva
  import efs_pkg::*;
(
  // Clock, reset, bus
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Pins and measurement
  input wire logic        enableTerminal,
  input wire logic [15:0] stageCurrentSum,
  input wire logic        stagesEnable,
  input wire logic        faultOutTerminal,
  input efs_led_type      statusLed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Enable rise held long enough to pass the synchroniser
  sequence enHeld;
    $rose(enableTerminal) ##1 (enableTerminal && faultOutTerminal)[*6];
  endsequence
  // Enable low with no fault latched
  sequence idleHeld;
    (!enableTerminal && faultOutTerminal)[*6];
  endsequence
  AST_EN_YELLOW: assert property (enHeld |-> statusLed inside {EFS_LED_YELLOW, EFS_LED_OFF})
    else $error("enable left the light green");
  AST_FLASH_OFF: assert property (statusLed == EFS_LED_OFF |-> !stagesEnable)
    else $error("stages on while light dark");
  AST_RUN_STEADY: assert property (stagesEnable |-> statusLed == EFS_LED_YELLOW)
    else $error("stages on without steady yellow");
  AST_OVERCUR: assert property (stageCurrentSum > `EFS_THRESH_RST |=> !stagesEnable)
    else $error("stages stayed on above threshold");
  AST_FAULT_RED: assert property (!faultOutTerminal |-> statusLed == EFS_LED_RED && !stagesEnable)
    else $error("fault without red light");
  AST_FAULT_HOLD: assert property ((enableTerminal && !faultOutTerminal)[*4] |=> !faultOutTerminal)
    else $error("fault cleared without enable toggle");
  AST_APB_READY: assert property (psel && !penable |=> pready && $past(psel))
    else $error("no ready in first access cycle");
  AST_IDLE_GREEN: assert property (idleHeld |-> statusLed == EFS_LED_GREEN)
    else $error("idle light not green");
endmodule : efs_supervisor_sva

// ---- efs_tb.sv ----
// Self-checking bench for the enable/fault supervisor
`timescale 1ns/1ns
`include "efs_cfg.svh"
module tb;
  import efs_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] stageSum = 16'h0100;
  logic [15:0] cmdCur = 16'h0100;
  logic [15:0] fbCur = 16'h0100;
  logic [7:0]  cause = 8'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, enableTerminal, stagesEnable;
  logic        faultOutTerminal, commandInputConnect, irq;
  logic        slvErr;
  logic [3:0]  pins;
  efs_led_type statusLed;
  int          err_count = 0;
  int          num_checks = 0;
  logic [4:0]  codes [8] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h08, 5'h0b, 5'h0f, 5'h10};
  always #2 clock = ~clock;
  assign pins = {commandInputConnect, statusLed == EFS_LED_GREEN, faultOutTerminal, stagesEnable};
  efs_ctrl_model ctl (.clock(clock), .faultOutTerminal(faultOutTerminal),
    .enableTerminal(enableTerminal));
  efs_supervisor #(.FLASH_NS(40)) dut (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enableTerminal(enableTerminal),
    .stageCurrentSum(stageSum), .commandCurrent(cmdCur), .feedbackCurrent(fbCur),
    .feedbackNegative(cause[5]), .commandNegative(cause[7]), .setANegOrOver(cause[6]),
    .setAWireBreak(cause[2]), .setBWireOrOverV(cause[3]), .feedbackWireBreak(cause[1]),
    .outStageWireBreak(cause[4]), .operationError(cause[0]), .stagesEnable(stagesEnable),
    .faultOutTerminal(faultOutTerminal), .commandInputConnect(commandInputConnect),
    .statusLed(statusLed), .irq(irq));
  task tally_and_finish;
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Wait hit its bound
  task tmo;
    err_count++;
    tally_and_finish();
  endtask : tmo
  // One APB transfer; read data lands in rd
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) tmo();
  endtask : apb
  // Bounded wait: 0 stages, 1 fault pin, 2 green, 3 command connect
  task waitPin(input int s, input logic v);
    int n;
    for (n = 0; n < 300 && pins[s] !== v; n++) @(posedge clock);
    if (n == 300) tmo();
  endtask : waitPin
  task scnNoDelay;
    chk(32'(statusLed), 32'(EFS_LED_GREEN));
    apb(1'b1, `EFS_OFF_DELAY, 32'h0);
    ctl.setEn(1'b1);
    waitPin(0, 1'b1);
    chk(32'(statusLed), 32'(EFS_LED_YELLOW));
    ctl.setEn(1'b0);
    waitPin(2, 1'b1);
    chk(32'(stagesEnable), 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    chk(32'(slvErr), 32'h0);
    apb(1'b1, 12'h040, 32'hffff_ffff);
    chk(32'(slvErr), 32'h0);
    apb(1'b0, `EFS_OFF_LIMITS, 32'h0);
    chk(rd, {`EFS_OVER_RST, `EFS_UNDER_RST});
    apb(1'b0, `EFS_OFF_THRESH, 32'h0);
    chk(rd, {`EFS_FB_OVER_RST, `EFS_THRESH_RST});
  endtask : scnNoDelay
  task scnDelay;
    int n;
    logic off;
    apb(1'b1, `EFS_OFF_DELAY, 32'd20);
    ctl.setEn(1'b1);
    waitPin(2, 1'b0);
    off = 1'b0;
    for (n = 0; n < 60 && stagesEnable !== 1'b1; n++) begin
      @(posedge clock);
      off |= statusLed === EFS_LED_OFF;
    end
    chk(32'(n >= 19 && n <= 23), 32'h1);
    chk(32'(off), 32'h1);
    off = 1'b0;
    repeat (24) @(posedge clock) off |= statusLed !== EFS_LED_YELLOW;
    chk(32'(off), 32'h0);
  endtask : scnDelay
  task scnOver;
    stageSum <= `EFS_THRESH_RST;
    repeat (4) @(posedge clock);
    chk(32'(stagesEnable), 32'h1);
    stageSum <= `EFS_THRESH_RST + 16'h1;
    repeat (2) @(posedge clock);
    chk({statusLed, faultOutTerminal, stagesEnable}, {EFS_LED_RED, 2'b00});
    apb(1'b0, `EFS_OFF_ERRCODE, 32'h0);
    stageSum <= 16'h0100;
    chk(rd, 32'h3);
    apb(1'b0, `EFS_OFF_STATUS, 32'h0);
    chk(rd, 32'h08);
    apb(1'b1, `EFS_OFF_INTMASK, 32'hff);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h1);
    apb(1'b1, `EFS_OFF_INTMASK, 32'h0);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
    apb(1'b1, `EFS_OFF_INTMASK, 32'hff);
    apb(1'b0, `EFS_OFF_INTSTAT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, `EFS_OFF_INTSTAT, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, `EFS_OFF_DELAY, 32'h0);
    apb(1'b0, `EFS_OFF_DELAY, 32'h5);
    chk(rd, 32'h0);
    chk(32'(faultOutTerminal), 32'h0);
    ctl.clearFault();
    waitPin(0, 1'b1);
    chk(32'(faultOutTerminal), 32'h1);
  endtask : scnOver
  task scnCodes;
    for (int i = 0; i < 8; i++) begin
      cause[i] <= 1'b1;
      waitPin(1, 1'b0);
      apb(1'b0, `EFS_OFF_ERRCODE, 32'h0);
      chk(rd, 32'(codes[i]));
      cause[i] <= 1'b0;
      ctl.clearFault();
      waitPin(0, 1'b1);
    end
  endtask : scnCodes
  task scnCmd;
    cmdCur <= `EFS_UNDER_RST - 16'h1;
    apb(1'b1, `EFS_OFF_CTRL, 32'h1);
    repeat (4) @(posedge clock);
    chk(32'(faultOutTerminal), 32'h1);
    apb(1'b1, `EFS_OFF_CTRL, 32'h3);
    waitPin(1, 1'b0);
    apb(1'b0, `EFS_OFF_ERRCODE, 32'h0);
    chk(rd, 32'h6);
    cmdCur <= 16'h0100;
    ctl.clearFault();
    waitPin(0, 1'b1);
    cmdCur <= `EFS_OVER_RST + 16'h1;
    waitPin(3, 1'b0);
    waitPin(1, 1'b0);
    apb(1'b0, `EFS_OFF_ERRCODE, 32'h0);
    chk(rd, 32'h10);
  endtask : scnCmd
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    scnNoDelay();
    scnDelay();
    scnOver();
    scnCodes();
    scnCmd();
    tally_and_finish();
  end
endmodule : tb
bind efs_supervisor efs_supervisor_sva chk (.clock(clock), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .enableTerminal(enableTerminal),
  .stageCurrentSum(stageCurrentSum), .stagesEnable(stagesEnable),
  .faultOutTerminal(faultOutTerminal), .statusLed(statusLed));
